// File: bsb_pkg.sv
// constants and carrier types for the branch, skip and bit-operation unit
// assumes a decoder upstream has already split the instruction word
package bsb_pkg;

  // ----------------------------------------------------------------
  // status flag positions and reset value
  // ----------------------------------------------------------------
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [2:0]  FLG_I_SEL = 3'h7;

  // ----------------------------------------------------------------
  // cycle counts, expressed as extra cycles beyond the first
  // ----------------------------------------------------------------
  localparam logic [1:0] XTRA_NONE   = 2'h0;
  localparam logic [1:0] XTRA_BRANCH = 2'h1;
  localparam logic [1:0] XTRA_SKIP1  = 2'h1;
  localparam logic [1:0] XTRA_SKIP2  = 2'h2;
  localparam logic [1:0] XTRA_IOBIT  = 2'h1;

  // ----------------------------------------------------------------
  // operations; named flag set/clear ops other than global_int_on/off arrive as the generic forms
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
    branch_carry_set, branch_carry_clear, branch_same_higher,
    branch_lower, branch_minus, branch_plus, branch_ge_signed,
    branch_lt_signed, branch_half_set, branch_half_clear,
    branch_tflag_set, branch_tflag_clear, branch_overflow_clear,
    branch_int_enabled, branch_int_disabled, io_bit_set, io_bit_clear,
    shift_left_logical, shift_right_logical, rotate_left_carry,
    rotate_right_carry, shift_right_arith, nibble_swap,
    flag_set_generic, flag_clear_generic, bit_to_tflag, tflag_to_bit,
    global_int_on, global_int_off
  } bsb_opc_t;

  typedef struct packed {
    bsb_opc_t    opc;
    logic [7:0]  reg_val;   // register operand as read
    logic [2:0]  bit_sel;   // b or s operand
    logic [5:0]  io_addr;
    logic [6:0]  offs;      // signed relative offset k
    logic        two_word;  // following instruction is two words
  } bsb_op_t;

  typedef struct packed {
    logic        we;
    logic [5:0]  addr;
    logic [7:0]  data;
  } bsb_io_wr_t;

endpackage : bsb_pkg

// File: bsb_exec.sv
// execution of skips, relative branches and bit/flag operations
// assumes i_op and i_io_rdata come from logic on i_mclk; i_io_rdata
// is the current value of the port at i_op.io_addr
`timescale 1ns/10ps
`default_nettype none
module bsb_exec
  import bsb_pkg::*;
#(
  parameter int unsigned PC_W = 16
)(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic              i_op_valid,
  input  wire bsb_op_t           i_op,
  input  wire logic [PC_W-1:0]   i_pc,
  input  wire logic [7:0]        i_io_rdata,
  output logic                   o_ready,
  output logic                   o_pc_load,
  output logic [PC_W-1:0]        o_pc_next,
  output logic                   o_rd_we,
  output logic [7:0]             o_rd_wdata,
  output var bsb_io_wr_t         o_io_wr,
  output logic [7:0]             o_flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_HOLD} bsb_state_t;

  bsb_state_t      state_reg, state_next;
  logic [1:0]      cnt_reg, cnt_next;
  logic [7:0]      flags_reg, flags_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic            load_reg;
  logic            rd_we_reg, rd_we_next;
  logic [7:0]      rd_reg, rd_next;
  bsb_io_wr_t      io_reg, io_next;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire bsb_opc_t opc = i_op.opc;
  wire acc   = i_op_valid && o_ready;
  wire fc    = flags_reg[FLG_C];
  wire fz    = flags_reg[FLG_Z];
  wire fn    = flags_reg[FLG_N];
  wire fv    = flags_reg[FLG_V];
  wire fh    = flags_reg[FLG_H];
  wire ft    = flags_reg[FLG_T];
  wire fi    = flags_reg[FLG_I];
  wire fsel  = flags_reg[i_op.bit_sel];
  wire rbit  = i_op.reg_val[i_op.bit_sel];
  wire iobit = i_io_rdata[i_op.bit_sel];

  wire br_take =
      (opc == branch_flag_set       &&  fsel)
    | (opc == branch_flag_clear     && !fsel)
    | (opc == branch_equal          &&  fz)
    | (opc == branch_not_equal      && !fz)
    | (opc == branch_carry_set      &&  fc)
    | (opc == branch_lower          &&  fc)
    | (opc == branch_carry_clear    && !fc)
    | (opc == branch_same_higher    && !fc)
    | (opc == branch_ge_signed      && !(fn ^ fv))
    | (opc == branch_lt_signed      &&  (fn ^ fv))
    | (opc == branch_half_set       &&  fh)
    | (opc == branch_half_clear     && !fh)
    | (opc == branch_tflag_set      &&  ft)
    | (opc == branch_tflag_clear    && !ft)
    | (opc == branch_minus          &&  fn)
    | (opc == branch_plus           && !fn)
    | (opc == branch_overflow_clear && !fv)
    | (opc == branch_int_enabled    &&  fi)
    | (opc == branch_int_disabled   && !fi);

  wire skip_take =
      (opc == skip_reg_bit_set  &&  rbit)
    | (opc == skip_io_bit_clear && !iobit)
    | (opc == skip_io_bit_set   &&  iobit);

  wire is_io_bit = (opc == io_bit_set) || (opc == io_bit_clear);

  // ----------------------------------------------------------------
  // program counter targets
  // ----------------------------------------------------------------
  wire [PC_W-1:0] offs_ext = {{(PC_W-7){i_op.offs[6]}}, i_op.offs};
  wire [PC_W-1:0] pc_inc1  = i_pc + PC_W'(1);
  wire [PC_W-1:0] pc_br    = i_pc + offs_ext + PC_W'(1);
  // the skipped instruction is passed whole, one or two words
  wire [PC_W-1:0] pc_skip  = i_op.two_word ? i_pc + PC_W'(3)
                                           : i_pc + PC_W'(2);
  wire [PC_W-1:0] pc_tgt   = br_take   ? pc_br
                           : skip_take ? pc_skip : pc_inc1;

  wire [1:0] xtra = br_take   ? XTRA_BRANCH
                  : skip_take ? (i_op.two_word ? XTRA_SKIP2
                                               : XTRA_SKIP1)
                  : is_io_bit ? XTRA_IOBIT : XTRA_NONE;

  // ----------------------------------------------------------------
  // shifts, rotates, and the t flag and io bit write results
  // ----------------------------------------------------------------
  wire [7:0] v = i_op.reg_val;
  wire is_shl = (opc == shift_left_logical) || (opc == rotate_left_carry);
  wire is_shr = (opc == shift_right_logical) || (opc == rotate_right_carry)
             || (opc == shift_right_arith);
  wire is_sh  = is_shl || is_shr;
  wire top_in = (opc == rotate_right_carry) ? fc
              : (opc == shift_right_arith)  ? v[7] : 1'b0;
  wire bot_in = (opc == rotate_left_carry)  ? fc : 1'b0;
  wire [7:0] sh_res = is_shl ? {v[6:0], bot_in}
                             : {top_in, v[7:1]};
  wire sh_c = is_shl ? v[7] : v[0];
  wire sh_n = sh_res[7];
  wire sh_z = (sh_res == 8'h00);

  wire [7:0] tload_res = (v & ~(8'h01 << i_op.bit_sel))
                       | ({7'h00, ft} << i_op.bit_sel);
  wire [7:0] io_res  = (opc == io_bit_set)
                     ? (i_io_rdata |  (8'h01 << i_op.bit_sel))
                     : (i_io_rdata & ~(8'h01 << i_op.bit_sel));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    flags_next = flags_reg;
    rd_we_next = 1'b0;
    rd_next    = rd_reg;
    io_next    = '{we: 1'b0, addr: io_reg.addr, data: io_reg.data};
    pc_next    = pc_reg;
    if (acc)
    begin
      pc_next = pc_tgt;
      if (is_sh)
      begin
        rd_we_next       = 1'b1;
        rd_next          = sh_res;
        flags_next[FLG_C] = sh_c;
        flags_next[FLG_Z] = sh_z;
        flags_next[FLG_N] = sh_n;
        flags_next[FLG_V] = sh_n ^ sh_c;
      end
      if (opc == nibble_swap)
      begin
        rd_we_next = 1'b1;
        rd_next    = {v[3:0], v[7:4]};
      end
      if (opc == bit_to_tflag)
        flags_next[FLG_T] = rbit;
      if (opc == tflag_to_bit)
      begin
        rd_we_next = 1'b1;
        rd_next    = tload_res;
      end
      if (opc == flag_set_generic)
        flags_next[i_op.bit_sel] = 1'b1;
      if (opc == flag_clear_generic)
        flags_next[i_op.bit_sel] = 1'b0;
      if (opc == global_int_on)
        flags_next[FLG_I] = 1'b1;
      if (opc == global_int_off)
        flags_next[FLG_I] = 1'b0;
      if (is_io_bit)
        io_next = '{we: 1'b1, addr: i_op.io_addr, data: io_res};
    end
  end

  // the unit stays not ready for the extra cycles of a slow operation
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (acc && xtra != XTRA_NONE)
        begin
          state_next = ST_HOLD;
          cnt_next   = xtra;
        end
      end
      ST_HOLD:
      begin
        cnt_next = cnt_reg - 2'h1;
        if (cnt_reg == 2'h1)
          state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 2'h0;
      flags_reg <= FLAGS_RST;
      pc_reg    <= '0;
      load_reg  <= 1'b0;
      rd_we_reg <= 1'b0;
      rd_reg    <= 8'h00;
      io_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      flags_reg <= flags_next;
      pc_reg    <= pc_next;
      load_reg  <= acc;
      rd_we_reg <= rd_we_next;
      rd_reg    <= rd_next;
      io_reg    <= io_next;
    end
  end

  assign o_ready    = (state_reg == ST_IDLE);
  assign o_pc_load  = load_reg;
  assign o_pc_next  = pc_reg;
  assign o_rd_we    = rd_we_reg;
  assign o_rd_wdata = rd_reg;
  assign o_io_wr    = io_reg;
  assign o_flags    = flags_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_skip_reg_taken: assert property (
    acc && opc == skip_reg_bit_set && rbit && !i_op.two_word
    |=> o_pc_next == $past(i_pc) + PC_W'(2) && o_flags == $past(flags_reg))
    else $error("register bit skip wrong target");

  a_skip_io_clear: assert property (
    acc && opc == skip_io_bit_clear && !iobit && i_op.two_word
    |=> o_pc_next == $past(i_pc) + PC_W'(3))
    else $error("io bit skip wrong target");

  a_skip_io_none: assert property (
    acc && opc == skip_io_bit_set && !iobit
    |=> o_pc_next == $past(i_pc) + PC_W'(1) && o_ready)
    else $error("io bit skip taken when bit clear");

  a_branch_flag: assert property (
    acc && opc == branch_flag_set && fsel
    |=> o_pc_next == $past(pc_br) && !o_ready ##1 o_ready)
    else $error("flag branch target or timing wrong");

  a_branch_equal: assert property (
    acc && opc == branch_equal |=> o_ready != $past(fz)
      && o_pc_next == $past(i_pc) + ($past(fz) ? $past(offs_ext) : '0)
         + PC_W'(1))
    else $error("equal branch ignores zero flag");

  a_branch_signed: assert property (
    acc && opc == branch_ge_signed && (fn ^ fv) |=> o_ready
      && o_pc_next == $past(pc_inc1))
    else $error("signed branch taken on wrong sign");

  a_branch_tflag: assert property (
    acc && opc == branch_tflag_clear && !ft |=> !o_ready)
    else $error("t flag branch not taken");

  a_branch_ovf: assert property (
    acc && opc == branch_overflow_clear && fv |=> o_ready)
    else $error("overflow branch taken with v set");

  a_branch_int: assert property (
    acc && opc == branch_int_enabled && fi
    |=> !o_ready && o_flags == $past(flags_reg))
    else $error("interrupt branch wrong");

  a_io_bit_write: assert property (
    acc && opc == io_bit_set |=> o_io_wr.we
      && o_io_wr.data == ($past(i_io_rdata) | (8'h01 << $past(i_op.bit_sel)))
      && !o_ready ##1 o_ready && !o_io_wr.we)
    else $error("io bit set wrong");

  a_shift_left: assert property (
    acc && opc == shift_left_logical |=> o_rd_we
      && o_rd_wdata == {$past(v[6:0]), 1'b0} && o_flags[FLG_C] == $past(v[7]))
    else $error("left shift wrong");

  a_sign_bit_keep: assert property (
    acc && opc == shift_right_arith |=> o_rd_wdata[7] == $past(v[7])
      && o_rd_wdata[6] == $past(v[7]) && o_flags[FLG_C] == $past(v[0]))
    else $error("arithmetic shift lost sign");

  a_bit_to_t: assert property (
    acc && opc == bit_to_tflag |=> o_flags[FLG_T] == $past(rbit) && !o_rd_we)
    else $error("bit store to t wrong");

  a_flag_one: assert property (
    acc && opc == flag_clear_generic |=> (o_flags ^ $past(flags_reg))
      == ($past(flags_reg) & (8'h01 << $past(i_op.bit_sel))) && o_ready)
    else $error("flag clear touched other flags");

  a_int_on: assert property (
    acc && opc == global_int_on |=> o_flags[FLG_I])
    else $error("interrupt enable did not set flag");

  a_skip_cycles: assert property (
    acc && skip_take && i_op.two_word |=> !o_ready [*2] ##1 o_ready)
    else $error("two word skip timing wrong");

  c_branch_taken: cover property (acc && br_take);
  c_skip_two_word: cover property (acc && skip_take && i_op.two_word);
  c_io_bit_clear: cover property (acc && opc == io_bit_clear);
  c_rotate_right: cover property (acc && opc == rotate_right_carry);

endmodule : bsb_exec
`default_nettype wire

// File: testbench.sv
// self-checking bench for bsb_exec: random and swept operations
// assumes bsb_pkg is compiled first; the bench plays the decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bsb_pkg::*;
  typedef struct packed {
    logic [15:0] pc;
    logic        rd_we;
    logic [7:0]  rd;
    logic        io_we;
    logic [7:0]  io;
    logic [7:0]  flags;
    logic [1:0]  extra;
  } bsb_exp_t;
  logic        i_mclk;
  logic        i_rst_b;
  logic        i_op_valid;
  bsb_op_t     i_op;
  logic [15:0] i_pc;
  logic [7:0]  i_io_rdata;
  logic        o_ready;
  logic        o_pc_load;
  logic [15:0] o_pc_next;
  logic        o_rd_we;
  logic [7:0]  o_rd_wdata;
  bsb_io_wr_t  o_io_wr;
  logic [7:0]  o_flags;
  logic [7:0]  flags_m;
  int          num_errors;
  int          n_checks;
  int          cycles;
  bsb_exec #(.PC_W(16)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_pc(i_pc),
    .i_io_rdata(i_io_rdata), .o_ready(o_ready), .o_pc_load(o_pc_load),
    .o_pc_next(o_pc_next), .o_rd_we(o_rd_we), .o_rd_wdata(o_rd_wdata),
    .o_io_wr(o_io_wr), .o_flags(o_flags));
  // ----------------------------------------------------------------
  // reference behaviour
  // ----------------------------------------------------------------
  function automatic bsb_exp_t predict(input bsb_op_t op,
    input logic [15:0] pc, input logic [7:0] io, input logic [7:0] s);
    bsb_exp_t   r;
    logic       tk;
    logic       sk;
    logic       sh;
    logic       cy;
    logic [7:0] rv;
    logic [7:0] v;
    logic [7:0] m;
    rv = op.reg_val;
    v = rv;
    m = 8'h01 << op.bit_sel;
    r = '0;
    r.flags = s;
    case (op.opc)
      branch_flag_set:      tk = s[op.bit_sel];
      branch_flag_clear:    tk = !s[op.bit_sel];
      branch_equal:         tk = s[FLG_Z];
      branch_not_equal:     tk = !s[FLG_Z];
      branch_carry_set,
      branch_lower:         tk = s[FLG_C];
      branch_carry_clear,
      branch_same_higher:   tk = !s[FLG_C];
      branch_minus:         tk = s[FLG_N];
      branch_plus:          tk = !s[FLG_N];
      branch_ge_signed:     tk = !(s[FLG_N] ^ s[FLG_V]);
      branch_lt_signed:     tk = s[FLG_N] ^ s[FLG_V];
      branch_half_set:      tk = s[FLG_H];
      branch_half_clear:    tk = !s[FLG_H];
      branch_tflag_set:     tk = s[FLG_T];
      branch_tflag_clear:   tk = !s[FLG_T];
      branch_overflow_clear: tk = !s[FLG_V];
      branch_int_enabled:   tk = s[FLG_I];
      branch_int_disabled:  tk = !s[FLG_I];
      default:              tk = 1'b0;
    endcase
    case (op.opc)
      skip_reg_bit_set:  sk = rv[op.bit_sel];
      skip_io_bit_clear: sk = !io[op.bit_sel];
      skip_io_bit_set:   sk = io[op.bit_sel];
      default:           sk = 1'b0;
    endcase
    r.pc = pc + 16'h0001;
    if (tk)
      r.pc = pc + {{9{op.offs[6]}}, op.offs} + 16'h0001;
    if (sk)
      r.pc = pc + (op.two_word ? 16'h0003 : 16'h0002);
    r.extra = sk ? (op.two_word ? 2'h2 : 2'h1) : {1'b0, tk};
    r.io_we = op.opc inside {io_bit_set, io_bit_clear};
    r.io = (op.opc == io_bit_set) ? (io | m) : (io & ~m);
    if (r.io_we)
      r.extra = 2'h1;
    case (op.opc)
      shift_left_logical:  v = {rv[6:0], 1'b0};
      shift_right_logical: v = {1'b0, rv[7:1]};
      rotate_left_carry:   v = {rv[6:0], s[FLG_C]};
      rotate_right_carry:  v = {s[FLG_C], rv[7:1]};
      shift_right_arith:   v = {rv[7], rv[7:1]};
      nibble_swap:         v = {rv[3:0], rv[7:4]};
      tflag_to_bit:        v[op.bit_sel] = s[FLG_T];
      flag_set_generic:    r.flags[op.bit_sel] = 1'b1;
      flag_clear_generic:  r.flags[op.bit_sel] = 1'b0;
      bit_to_tflag:        r.flags[FLG_T] = rv[op.bit_sel];
      global_int_on:       r.flags[FLG_I] = 1'b1;
      global_int_off:      r.flags[FLG_I] = 1'b0;
      default:             v = rv;
    endcase
    sh = op.opc inside {shift_left_logical, shift_right_logical,
      rotate_left_carry, rotate_right_carry, shift_right_arith};
    cy = (op.opc inside {shift_left_logical, rotate_left_carry}) ?
      rv[7] : rv[0];
    r.rd_we = sh || op.opc inside {nibble_swap, tflag_to_bit};
    r.rd = v;
    if (sh)
    begin
      r.flags[FLG_Z] = (v == 8'h00);
      r.flags[FLG_C] = cy;
      r.flags[FLG_N] = v[7];
      r.flags[FLG_V] = v[7] ^ cy;
    end
    return r;
  endfunction : predict
  function automatic bsb_op_t rand_op(input int opc);
    bsb_op_t o;
    o = bsb_op_t'($bits(bsb_op_t)'($urandom));
    o.opc = bsb_opc_t'(6'(opc));
    return o;
  endfunction : rand_op
  function automatic bsb_op_t sel_op(input int opc, input int b);
    bsb_op_t o;
    o = rand_op(opc);
    o.bit_sel = 3'(b);
    return o;
  endfunction : sel_op
  // ----------------------------------------------------------------
  // checking and driving
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // requests made while busy are expected to be ignored
  task automatic run_op(input bsb_op_t op);
    bsb_exp_t e;
    i_op_valid = 1'b1;
    i_op = op;
    i_pc = 16'($urandom);
    i_io_rdata = 8'($urandom);
    e = predict(op, i_pc, i_io_rdata, flags_m);
    @(negedge i_mclk);
    check("pc_load", o_pc_load, 16'h1);
    if (op.opc inside {skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set})
      check("pc_skip", o_pc_next, e.pc);
    else
      check("pc", o_pc_next, e.pc);
    check("flags", o_flags, e.flags);
    check("rd_we", o_rd_we, e.rd_we);
    check("io_we", o_io_wr.we, e.io_we);
    if (e.rd_we)
      check("rd_wdata", o_rd_wdata, e.rd);
    if (e.io_we)
      check("io_addr", o_io_wr.addr, op.io_addr);
    if (e.io_we)
      check("io_data", o_io_wr.data, e.io);
    flags_m = e.flags;
    for (int k = 0; k < e.extra; k++)
    begin
      i_op = rand_op($urandom_range(36));
      i_io_rdata = 8'($urandom);
      check("ready_busy", o_ready, 16'h0);
      @(negedge i_mclk);
      check("pc_load_busy", o_pc_load, 16'h0);
      check("io_we_busy", o_io_wr.we, 16'h0);
    end
    check("ready_idle", o_ready, 16'h1);
  endtask : run_op
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_rst_b = 1'b0;
    i_op_valid = 1'b0;
    i_op = '0;
    i_pc = 16'h0000;
    i_io_rdata = 8'h00;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    flags_m = FLAGS_RST;
    void'($urandom(30387));
    repeat (16) @(negedge i_mclk);
    check("flags_rst", o_flags, FLAGS_RST);
    i_rst_b = 1'b1;
    for (int w = 0; w < 2; w++)
      for (int c = 0; c < 37; c++)
        run_op(rand_op(c));
    // each flag set and branched on, then cleared and branched on
    for (int s = 0; s < 8; s++)
    begin
      run_op(sel_op(flag_set_generic, s));
      run_op(sel_op(branch_flag_set, s));
      run_op(sel_op(flag_clear_generic, s));
      run_op(sel_op(branch_flag_clear, s));
    end
    for (int n = 0; n < 700; n++)
      run_op(rand_op($urandom_range(36)));
    i_op_valid = 1'b0;
    i_rst_b = 1'b0;
    @(negedge i_mclk);
    check("flags_rst2", o_flags, FLAGS_RST);
    check("ready_rst", o_ready, 16'h1);
    check("pc_rst", o_pc_next, 16'h0000);
    flags_m = FLAGS_RST;
    i_rst_b = 1'b1;
    for (int n = 0; n < 300; n++)
      run_op(rand_op($urandom_range(36)));
    i_op_valid = 1'b0;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
